// ### design/dhc_host_port.sv
// Host command port: task file, busy, requests, ECC policy, clocks
`timescale 1ns/100ps
`include "dhc_params.svh"
module dhc_host_port #(
	parameter int SELFTEST_CYCLES = 256,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic master_reset_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] host_data_lines_in,
	output logic [7:0] host_data_lines_out,
	output logic host_data_lines_oe,
	output logic data_request,
	output logic interrupt_request,
	output logic ref_clock,
	output logic write_clock,
	output logic floppy_clock,
	output logic diskValid,
	input wire logic diskReady,
	output logic [7:0] diskData,
	input wire logic hardFault,
	input wire logic floppyCrcFault,
	input wire logic syndromeZero,
	input wire logic syndromeMatch,
	input wire logic correctable,
	input wire logic diskDone
);
	dhc_pkg::dhc_state_t state_r;
	logic [7:0] error_r, count_r, sector_r, cylLo_r, cylHi_r, sdh_r, cmd_r;
	logic [15:0] timer_r;
	logic [10:0] bytes_r;
	logic [3:0] retry_r;
	logic [2:0] eccIdx_r;
	logic [31:0] ecc_r;
	logic busy, reset_r, wrPulse, rdPulse, rdLast_r, wrLast_r;
	logic [10:0] secBytes;
	logic fifoInReady, fifoOutValid;
	logic [7:0] fifoOutData;
	logic isFloppy, isBuffered;
	logic [7:0] statusByte;
	logic [0:0] refDiv_r, wrDiv_r;
	logic [2:0] flDiv_r;

	assign busy = (state_r == dhc_pkg::ST_EXEC) || (state_r == dhc_pkg::ST_ECC) || (state_r == dhc_pkg::ST_DONE) ||
		reset_r;
	assign isFloppy = (sdh_r[4:3] == 2'b11);
	assign isBuffered = (cmd_r[2:0] == 3'(dhc_pkg::CMD_WRITE)) || (cmd_r[2:0] == 3'(dhc_pkg::CMD_FORMAT));
	assign secBytes = 11'h080 << sdh_r[`DHC_SDH_SIZE_LSB +: 2];
	assign wrPulse = !chip_select_n && !write_strobe_n && wrLast_r;
	assign rdPulse = !chip_select_n && !read_strobe_n && rdLast_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wrLast_r <= 1'b1;
			rdLast_r <= 1'b1;
		end else begin
			wrLast_r <= chip_select_n || write_strobe_n;
			rdLast_r <= chip_select_n || read_strobe_n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reset_r <= 1'b1;
		end else if (!master_reset_n) begin
			reset_r <= 1'b1;
		end else if (timer_r == 16'(SELFTEST_CYCLES)) begin
			reset_r <= 1'b0;
		end
	end

	assign statusByte = {busy, 1'b1, 2'b00, data_request, 2'b00, error_r != 8'h00};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			host_data_lines_out <= 8'h00;
			host_data_lines_oe <= 1'b0;
		end else begin
			host_data_lines_oe <= !chip_select_n && !read_strobe_n;
			if (busy) begin
				host_data_lines_out <= statusByte;
			end else if (reg_addr == `DHC_REG_CMD) begin
				host_data_lines_out <= statusByte;
			end else if (reg_addr == `DHC_REG_ERROR) begin
				host_data_lines_out <= error_r;
			end else if (reg_addr == `DHC_REG_COUNT) begin
				host_data_lines_out <= count_r;
			end else if (reg_addr == `DHC_REG_SECTOR) begin
				host_data_lines_out <= sector_r;
			end else if (reg_addr == `DHC_REG_CYL_LO) begin
				host_data_lines_out <= cylLo_r;
			end else if (reg_addr == `DHC_REG_CYL_HI) begin
				host_data_lines_out <= cylHi_r;
			end else if (reg_addr == `DHC_REG_SDH) begin
				host_data_lines_out <= sdh_r;
			end else begin
				host_data_lines_out <= 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count_r <= 8'h01;
			sector_r <= 8'h01;
			cylLo_r <= 8'h00;
			cylHi_r <= 8'h00;
			sdh_r <= 8'h20;
			cmd_r <= 8'h00;
		end else if (wrPulse && !busy) begin
			if (reg_addr == `DHC_REG_COUNT) begin
				count_r <= host_data_lines_in;
			end else if (reg_addr == `DHC_REG_SECTOR) begin
				sector_r <= host_data_lines_in;
			end else if (reg_addr == `DHC_REG_CYL_LO) begin
				cylLo_r <= host_data_lines_in;
			end else if (reg_addr == `DHC_REG_CYL_HI) begin
				cylHi_r <= host_data_lines_in;
			end else if (reg_addr == `DHC_REG_SDH) begin
				sdh_r <= host_data_lines_in;
			end else if (reg_addr == `DHC_REG_CMD) begin
				cmd_r <= host_data_lines_in;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || !master_reset_n) begin
			state_r <= dhc_pkg::ST_IDLE;
			bytes_r <= 11'h000;
			retry_r <= 4'h0;
			error_r <= 8'h00;
			timer_r <= 16'h0000;
		end else if (reset_r) begin
			timer_r <= timer_r + 16'h0001;
		end else begin
			case (state_r)
				dhc_pkg::ST_IDLE: begin
					timer_r <= 16'h0000;
					if (wrPulse && reg_addr == `DHC_REG_CMD) begin
						error_r <= 8'h00;
						retry_r <= 4'h0;
						bytes_r <= 11'h000;
						if (host_data_lines_in[2:0] > 3'(dhc_pkg::CMD_FORMAT)) begin
							error_r[`DHC_ERR_ABORT] <= 1'b1;
							state_r <= dhc_pkg::ST_DONE;
						end else if (host_data_lines_in[2:0] == 3'(dhc_pkg::CMD_WRITE) ||
								host_data_lines_in[2:0] == 3'(dhc_pkg::CMD_FORMAT)) begin
							state_r <= dhc_pkg::ST_FILL;
						end else begin
							state_r <= dhc_pkg::ST_EXEC;
						end
					end
				end
				dhc_pkg::ST_FILL: begin
					if (wrPulse && reg_addr == `DHC_REG_DATA && fifoInReady) begin
						bytes_r <= bytes_r + 11'h001;
						if (bytes_r == secBytes - 11'h001) begin
							state_r <= dhc_pkg::ST_EXEC;
						end
					end
				end
				dhc_pkg::ST_EXEC: begin
					if (!fifoOutValid && diskDone) begin
						if (isBuffered && !isFloppy && sdh_r[`DHC_SDH_ECC]) begin
							state_r <= dhc_pkg::ST_ECC;
						end else if (cmd_r[2:0] == 3'(dhc_pkg::CMD_READ) && !syndromeZero && !isFloppy) begin
							if (syndromeMatch && correctable) begin
								state_r <= dhc_pkg::ST_DONE;
							end else if (syndromeMatch) begin
								error_r[`DHC_ERR_ECC] <= 1'b1;
								state_r <= dhc_pkg::ST_DONE;
							end else if (retry_r == `DHC_MAX_RETRY) begin
								error_r[`DHC_ERR_ECC] <= 1'b1;
								state_r <= dhc_pkg::ST_DONE;
							end else begin
								retry_r <= retry_r + 4'h1;
							end
						end else begin
							error_r[`DHC_ERR_ABORT] <= hardFault;
							error_r[`DHC_ERR_CRC] <= isFloppy && floppyCrcFault;
							state_r <= dhc_pkg::ST_DONE;
						end
					end
				end
				dhc_pkg::ST_ECC: begin
					if (diskReady && eccIdx_r == `DHC_ECC_BYTES - 3'h1) begin
						state_r <= dhc_pkg::ST_DONE;
					end
				end
				dhc_pkg::ST_DONE: begin
					state_r <= (cmd_r[2:0] == 3'(dhc_pkg::CMD_READ) && error_r == 8'h00) ?
						dhc_pkg::ST_XFER : dhc_pkg::ST_IDLE;
					bytes_r <= 11'h000;
				end
				dhc_pkg::ST_XFER: begin
					if (rdPulse && reg_addr == `DHC_REG_DATA) begin
						bytes_r <= bytes_r + 11'h001;
						if (bytes_r == secBytes - 11'h001) begin
							state_r <= dhc_pkg::ST_IDLE;
						end
					end
				end
				default: state_r <= dhc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || state_r == dhc_pkg::ST_IDLE) begin
			ecc_r <= `DHC_ECC_SEED;
			eccIdx_r <= 3'h0;
		end else if (fifoOutValid && diskReady) begin
			ecc_r <= {ecc_r[23:0], ecc_r[31:24] ^ fifoOutData};
		end else if (state_r == dhc_pkg::ST_ECC && diskReady) begin
			eccIdx_r <= eccIdx_r + 3'h1;
		end
	end
	assign diskValid = fifoOutValid || (state_r == dhc_pkg::ST_ECC);
	assign diskData = fifoOutValid ? fifoOutData : ecc_r[8*(3-eccIdx_r[1:0]) +: 8];

	always_ff @(posedge core_clk) begin
		if (!rst_n || !master_reset_n) begin
			data_request <= 1'b0;
		end else if ((wrPulse || rdPulse) && reg_addr == `DHC_REG_DATA) begin
			data_request <= 1'b0;
		end else begin
			data_request <= (state_r == dhc_pkg::ST_FILL && fifoInReady) || (state_r == dhc_pkg::ST_XFER);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || !master_reset_n) begin
			interrupt_request <= 1'b0;
		end else if (state_r == dhc_pkg::ST_DONE) begin
			interrupt_request <= 1'b1;
		end else if (rdPulse && reg_addr == `DHC_REG_CMD) begin
			interrupt_request <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			refDiv_r <= 1'b0;
			wrDiv_r <= 1'b0;
		end else begin
			refDiv_r <= ~refDiv_r;
			if (refDiv_r == 1'b1) begin
				wrDiv_r <= ~wrDiv_r;
			end
		end
	end
	assign ref_clock = refDiv_r[0];
	assign write_clock = wrDiv_r[0];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flDiv_r <= 3'h0;
			floppy_clock <= 1'b0;
		end else if (refDiv_r == 1'b1) begin
			flDiv_r <= (flDiv_r == 3'(`DHC_FLOPPY_DIV / 2 - 1)) ? 3'h0 : flDiv_r + 3'h1;
			if (flDiv_r == 3'(`DHC_FLOPPY_DIV / 2 - 1)) begin
				floppy_clock <= ~floppy_clock;
			end
		end
	end

	dhc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n && master_reset_n),
		.inValid(state_r == dhc_pkg::ST_FILL && wrPulse && reg_addr == `DHC_REG_DATA),
		.inReady(fifoInReady),
		.inData(host_data_lines_in),
		.outValid(fifoOutValid),
		.outReady(diskReady && (state_r == dhc_pkg::ST_FILL || state_r == dhc_pkg::ST_EXEC)),
		.outData(fifoOutData)
	);
endmodule : dhc_host_port

// ### design/dhc_params.svh
// Constants for the disk controller host command port
// How it works
// - Six commands: test, restore, seek, read, write, format
// - Busy after buffer fill or command
// - While busy only status polling works
// - Completion raises request and clears busy on the same clock edge
// - Eight-bit bus, host drives when idle
// - Data request flags pending DMA transfer
// - Interrupt request after commands
// - Four ECC bytes appended on writes
// - Up to eight retries on mismatch
// - Correct on agreeing correctable syndromes, else terminate
// - Status merges hard, floppy, ECC errors
// - Divide 20 MHz by 2, then 2
// - Floppy clock is reference over ten
// - ECC command register shows error info
// - Floppy data uses CRC only
// - Sector size 128 to 1024 bytes
`ifndef DHC_PARAMS_SVH
`define DHC_PARAMS_SVH
`define DHC_REG_DATA 3'h0
`define DHC_REG_ERROR 3'h1
`define DHC_REG_COUNT 3'h2
`define DHC_REG_SECTOR 3'h3
`define DHC_REG_CYL_LO 3'h4
`define DHC_REG_CYL_HI 3'h5
`define DHC_REG_SDH 3'h6
`define DHC_REG_CMD 3'h7
`define DHC_ST_BUSY 7
`define DHC_ST_READY 6
`define DHC_ST_DRQ 3
`define DHC_ST_ERR 0
`define DHC_SDH_ECC 7
`define DHC_SDH_SIZE_LSB 5
`define DHC_ERR_ECC 6
`define DHC_ERR_CRC 5
`define DHC_ERR_ABORT 2
`define DHC_MAX_RETRY 4'h8
`define DHC_ECC_BYTES 3'h4
`define DHC_REF_DIV 2
`define DHC_WR_DIV 2
`define DHC_FLOPPY_DIV 10
`define DHC_OSC_MHZ 20
`define DHC_SELFTEST_CYCLES 16'h0100
`define DHC_EXEC_CYCLES 16'h0040
`define DHC_ECC_SEED 32'hffffffff
`endif

// ### design/dhc_pkg.sv
// Types for the disk controller host command port
package dhc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FILL = 3'b001,
		ST_EXEC = 3'b010,
		ST_ECC = 3'b011,
		ST_DONE = 3'b100,
		ST_XFER = 3'b101
	} dhc_state_t;
	typedef enum logic [2:0] {
		CMD_TEST = 3'b000,
		CMD_RESTORE = 3'b001,
		CMD_SEEK = 3'b010,
		CMD_READ = 3'b011,
		CMD_WRITE = 3'b100,
		CMD_FORMAT = 3'b101
	} dhc_cmd_t;
endpackage : dhc_pkg

// ### design/dhc_fifo.sv
// Parameterised FIFO for the sector data path
`timescale 1ns/100ps
module dhc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic doWr;
	logic doRd;
	assign inReady = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	always_ff @(posedge core_clk) begin
		if (doWr) begin
			mem[wrPtr_r] <= inData;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doWr) begin
				wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
			end
			if (doRd) begin
				rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule : dhc_fifo

// ### bench/dhc_host_port_monitor.sv
// Checker for the host command port
`timescale 1ns/100ps
module dhc_host_port_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic master_reset_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic [2:0] reg_addr,
	input wire logic host_data_lines_oe,
	input wire logic interrupt_request,
	input wire logic ref_clock,
	input wire logic write_clock,
	input wire logic floppy_clock,
	input wire logic diskValid,
	input wire logic diskReady,
	input wire logic [7:0] diskData
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire statusRd = !chip_select_n && !read_strobe_n && reg_addr == 3'h7;
	sequence wrHigh;
		##1 write_clock;
	endsequence
	sequence wrLow;
		##1 !write_clock ##1 !write_clock ##1 write_clock;
	endsequence
	chk_ref_toggle: assert property ($past(rst_n) |-> ref_clock != $past(ref_clock))
		else $error("ref clock stuck");
	chk_wr_period: assert property ($rose(write_clock) |-> wrHigh ##0 wrLow)
		else $error("write clock period");
	chk_flop_high: assert property ($rose(floppy_clock) |-> ##10 $fell(floppy_clock))
		else $error("floppy clock high time");
	chk_flop_low: assert property ($fell(floppy_clock) |-> ##10 $rose(floppy_clock))
		else $error("floppy clock low time");
	chk_oe_on: assert property (!chip_select_n && !read_strobe_n |=> host_data_lines_oe)
		else $error("bus not driven on read");
	chk_oe_off: assert property (chip_select_n || read_strobe_n |=> !host_data_lines_oe)
		else $error("bus driven outside read");
	chk_intr_clear: assert property (statusRd && interrupt_request |-> ##[1:2] !interrupt_request)
		else $error("interrupt not cleared");
	chk_intr_hold: assert property (interrupt_request && !statusRd && master_reset_n |=> interrupt_request)
		else $error("interrupt dropped");
	chk_disk_hold: assert property (diskValid && !diskReady |=> diskValid && $stable(diskData))
		else $error("disk byte not held");
endmodule : dhc_host_port_monitor
bind dhc_host_port dhc_host_port_monitor dhc_host_port_monitor_i (.core_clk, .rst_n, .master_reset_n,
	.chip_select_n, .read_strobe_n, .reg_addr, .host_data_lines_oe, .interrupt_request, .ref_clock,
	.write_clock, .floppy_clock, .diskValid, .diskReady, .diskData);

// ### bench/dhc_disk_model.sv
// Disk-side partner: takes the byte stream, stalls, reports completion
`timescale 1ns/100ps
module dhc_disk_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic doneEn,
	input wire logic diskValid,
	input wire logic [7:0] diskData,
	output logic diskReady,
	output logic diskDone,
	output logic [15:0] byteCount
);
	logic [7:0] byteLog [0:511];
	logic [2:0] phase_r;
	logic [3:0] idle_r;
	assign diskReady = !slow || phase_r == 3'h0;
	assign diskDone = doneEn && idle_r == 4'hf;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_r <= 3'h0;
			idle_r <= 4'h0;
			byteCount <= 16'h0;
		end else begin
			phase_r <= phase_r + 3'h1;
			idle_r <= diskValid ? 4'h0 : (idle_r == 4'hf ? idle_r : idle_r + 4'h1);
			if (diskValid && diskReady) begin
				byteLog[byteCount[8:0]] <= diskData;
				byteCount <= byteCount + 16'h1;
			end
		end
	end
endmodule : dhc_disk_model

// ### bench/testbench.sv
// Testbench for the host command port
`timescale 1ns/100ps
module testbench;
	logic core_clk, rst_n, master_reset_n, chip_select_n, read_strobe_n, write_strobe_n, slow, doneEn;
	logic [2:0] reg_addr;
	logic [7:0] host_data_lines_in, host_data_lines_out, diskData, rdData;
	logic host_data_lines_oe, data_request, interrupt_request, ref_clock, write_clock, floppy_clock;
	logic diskValid, diskReady, diskDone, hardFault, floppyCrcFault, syndromeZero, syndromeMatch, correctable;
	logic [15:0] byteCount, base;
	int failures, samples_checked;
	typedef struct packed {logic [2:0] cmd; logic [7:0] sdh; logic [4:0] flt; logic [7:0] err;} dhc_row_t;
	dhc_row_t rows [10] = '{'{3'h0, 8'h00, 5'h04, 8'h00}, '{3'h1, 8'h00, 5'h04, 8'h00},
		'{3'h2, 8'h00, 5'h04, 8'h00}, '{3'h3, 8'h80, 5'h04, 8'h00}, '{3'h3, 8'h80, 5'h00, 8'h40},
		'{3'h3, 8'h80, 5'h03, 8'h00}, '{3'h3, 8'h80, 5'h02, 8'h40}, '{3'h3, 8'h98, 5'h0c, 8'h20},
		'{3'h2, 8'h00, 5'h14, 8'h04}, '{3'h6, 8'h00, 5'h04, 8'h04}};
	logic [7:0] wSdh [3] = '{8'h80, 8'h20, 8'h98};
	logic [2:0] wCmd [3] = '{3'h4, 3'h4, 3'h5};
	logic [15:0] wCnt [3] = '{16'h0084, 16'h0100, 16'h0080};
	dhc_host_port #(.SELFTEST_CYCLES(16)) dhc_host_port_i (.core_clk, .rst_n, .master_reset_n, .chip_select_n,
		.read_strobe_n, .write_strobe_n, .reg_addr, .host_data_lines_in, .host_data_lines_out,
		.host_data_lines_oe, .data_request, .interrupt_request, .ref_clock, .write_clock, .floppy_clock,
		.diskValid, .diskReady, .diskData, .hardFault, .floppyCrcFault, .syndromeZero, .syndromeMatch,
		.correctable, .diskDone);
	dhc_disk_model dhc_disk_model_i (.core_clk, .rst_n, .slow, .doneEn, .diskValid, .diskData, .diskReady,
		.diskDone, .byteCount);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic hostAcc(input logic wr, input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		chip_select_n <= 1'h0;
		read_strobe_n <= wr;
		write_strobe_n <= !wr;
		reg_addr <= a;
		host_data_lines_in <= d;
		repeat (4) @(posedge core_clk);
		rdData = host_data_lines_out;
		chip_select_n <= 1'h1;
		read_strobe_n <= 1'h1;
		write_strobe_n <= 1'h1;
	endtask : hostAcc
	task automatic waitIdle();
		int n;
		n = 0;
		rdData = 8'h80;
		while (rdData[7] !== 1'h0 && n < 200) begin
			hostAcc(1'h0, 3'h7, 8'h00);
			n++;
		end
		chk(rdData[7], 1'h0, "busy stuck");
	endtask : waitIdle
	task automatic finishCmd();
		int n;
		n = 0;
		doneEn <= 1'h1;
		while (interrupt_request !== 1'h1 && n < 5000) begin
			@(posedge core_clk);
			n++;
		end
		doneEn <= 1'h0;
		chk(interrupt_request, 1'h1, "no interrupt");
	endtask : finishCmd
	task automatic end_sim();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		#600000;
		failures++;
		end_sim();
	end
	initial begin
		{rst_n, slow, doneEn, reg_addr, host_data_lines_in} = '0;
		{master_reset_n, chip_select_n, read_strobe_n, write_strobe_n} = 4'hf;
		{hardFault, floppyCrcFault, syndromeZero, syndromeMatch, correctable} = 5'h04;
		failures = 0;
		samples_checked = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		hostAcc(1'h0, 3'h7, 8'h00);
		chk(rdData[7], 1'h1, "self-test busy");
		hostAcc(1'h1, 3'h2, 8'h55);
		waitIdle();
		hostAcc(1'h0, 3'h2, 8'h00);
		chk(rdData === 8'h55, 1'h0, "write taken while busy");
		foreach (rows[i]) begin
			{hardFault, floppyCrcFault, syndromeZero, syndromeMatch, correctable} <= rows[i].flt;
			hostAcc(1'h1, 3'h6, rows[i].sdh);
			hostAcc(1'h1, 3'h7, {5'h00, rows[i].cmd});
			if (rows[i].cmd < 3'h6) begin
				hostAcc(1'h0, 3'h7, 8'h00);
				chk({rdData[7], interrupt_request}, 2'h2, "busy on command");
			end
			finishCmd();
			hostAcc(1'h0, 3'h1, 8'h00);
			chk(rdData, rows[i].err, "error register");
			hostAcc(1'h0, 3'h7, 8'h00);
			chk({rdData[7], rdData[3], rdData[0], interrupt_request},
				{1'h0, rows[i].cmd == 3'h3 && rows[i].err == 8'h00, rows[i].err != 8'h00, 1'h0}, "status");
			if (rows[i].cmd == 3'h3)
				repeat (128) hostAcc(1'h0, 3'h0, 8'h00);
		end
		for (int k = 0; k < 3; k++) begin
			slow <= k != 1;
			base = byteCount;
			hostAcc(1'h1, 3'h6, wSdh[k]);
			hostAcc(1'h1, 3'h7, {5'h00, wCmd[k]});
			hostAcc(1'h0, 3'h7, 8'h00);
			chk(rdData[7], 1'h0, "busy before fill");
			for (int j = 0; j < (16'h0080 << wSdh[k][6:5]); j++) begin
				for (int n = 0; n < 400 && data_request !== 1'h1; n++)
					@(posedge core_clk);
				chk(data_request, 1'h1, "no data request");
				hostAcc(1'h1, 3'h0, j[7:0]);
			end
			hostAcc(1'h0, 3'h7, 8'h00);
			chk(rdData[7], 1'h1, "busy after fill");
			finishCmd();
			hostAcc(1'h0, 3'h7, 8'h00);
			chk(byteCount - base, wCnt[k], "disk byte count");
			chk(dhc_disk_model_i.byteLog[9'(base + 16'h007f)], 8'h7f, "disk byte order");
		end
		master_reset_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		master_reset_n <= 1'h1;
		hostAcc(1'h0, 3'h7, 8'h00);
		chk(rdData[7], 1'h1, "self-test after reset");
		waitIdle();
		end_sim();
	end
endmodule : testbench
